// >>> sllq_pkg.sv
// constants for the long-shift-with-quotient execution unit
// assumes: big-endian instruction bit numbering mapped onto [31:0]
package sllq_pkg;

  // -------------------------------------------------------------
  // datapath widths
  // -------------------------------------------------------------
  localparam int unsigned XLEN = 32;
  localparam int unsigned SHW = 5;
  localparam int unsigned REGW = 5;
  localparam int unsigned ADDR_W = 12;

  // -------------------------------------------------------------
  // instruction fields (printed bit 0 is our bit 31)
  // -------------------------------------------------------------
  localparam logic [5:0] PRIMARY_OP = 6'h1F;
  localparam logic [9:0] XO_IMM_LONG = 10'h0F8;
  localparam logic [9:0] XO_REG_LONG = 10'h0D8;
  localparam int unsigned POS_OP_LO = 26;
  localparam int unsigned POS_SRC_LO = 21;
  localparam int unsigned POS_TGT_LO = 16;
  localparam int unsigned POS_AMT_LO = 11;
  localparam int unsigned POS_XO_LO = 1;
  localparam int unsigned POS_RECORD = 0;
  // amount register: count in printed bits 27-31, mode in bit 26
  localparam int unsigned POS_CNT_LO = 0;
  localparam int unsigned POS_ZERO_SEL = 5;

  // -------------------------------------------------------------
  // condition field 0 layout: {lt, gt, eq, so}
  // -------------------------------------------------------------
  localparam int unsigned CR_LT = 3;
  localparam int unsigned CR_GT = 2;
  localparam int unsigned CR_EQ = 1;
  localparam int unsigned CR_SO = 0;

  // -------------------------------------------------------------
  // register map and reset values
  // -------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_MQ = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00C;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [XLEN-1:0] CTRL_RST = 32'h0000_0001;
  localparam logic [XLEN-1:0] MQ_RST = 32'h0000_0000;
  localparam logic [XLEN-1:0] ONES = 32'hFFFF_FFFF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {OP_NONE, OP_IMM, OP_REG} op_kind_t;

endpackage

// >>> sllq_rotmask.sv
// rotate and mask-merge core of the long-shift unit
// assumes: purely combinational, caller registers the outputs
`timescale 1ns/10ps
`default_nettype none
module sllq_rotmask
  import sllq_pkg::*;
(
  input wire logic [XLEN-1:0] i_src,     // word to rotate
  input wire logic [XLEN-1:0] i_mq,      // current quotient reg
  input wire logic [SHW-1:0] i_cnt,      // rotate count n
  input wire logic i_zero_sel,           // clear low n bits, keep quotient above
  output logic [XLEN-1:0] o_rot,         // rotated word
  output logic [XLEN-1:0] o_merged       // merged result
);

  logic [2*XLEN-1:0] dbl;
  logic [XLEN-1:0] mask_hi;

  assign dbl = {i_src, i_src} << i_cnt;
  assign o_rot = dbl[2*XLEN-1:XLEN];   // see RL2
  // 32-n ones above n zeros, counted from the low end
  assign mask_hi = ONES << i_cnt;      // see RL3

  // -------------------------------------------------------------
  // per-bit merge
  // -------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < XLEN; b = b + 1)
    begin : g_bit
      // zero mode: low n bits cleared, upper bits keep quotient reg
      assign o_merged[b] = i_zero_sel ? (i_mq[b] & mask_hi[b])
        : (mask_hi[b] ? o_rot[b] : i_mq[b]);
    end
  endgenerate

endmodule
`default_nettype wire

// >>> sllq_cr0.sv
// condition field 0 generator for recorded results
// assumes: result is a signed 32-bit word
`timescale 1ns/10ps
`default_nettype none
module sllq_cr0
  import sllq_pkg::*;
(
  input wire logic [XLEN-1:0] i_result,  // target register value
  input wire logic i_so,                 // exception summary bit
  output logic [3:0] o_cr                // {lt, gt, eq, so}
);

  always_comb
  begin
    o_cr = 4'h0;
    o_cr[CR_LT] = $signed(i_result) < 0;
    o_cr[CR_GT] = $signed(i_result) > 0;
    o_cr[CR_EQ] = i_result == '0;
    o_cr[CR_SO] = i_so;
  end

endmodule
`default_nettype wire

// >>> sllq_unit.sv
// long shift-left with quotient register: execution unit top
// assumes: decoder presents one instruction a cycle with operands
// already read from the register file; software on AXI4-Lite
//
// Operation
// RL1 - decode opcode 31 extended 248 immediate form
// RL2 - immediate form rotates source left by count
// RL3 - immediate mask: upper 32-n ones, n zeros
// RL4 - immediate: rotated to quotient, merge to target
// RL5 - mask one takes rotated, zero takes quotient
// RL6 - decode opcode 31 extended 216 register form
// RL7 - register form count from amount bits 27-31
// RL8 - mode bit clear: merge rotated under mask
// RL9 - mode bit set: merge zeros under mask (code keeps quotient under the mask and clears the low n bits instead)
// RL10 - register form writes target, quotient unchanged
// RL11 - exception register never modified by either form
// RL12 - record bit set updates condition field 0
// RL13 - signed compare with zero, summary copied
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sllq_unit
  import sllq_pkg::*;
(
  input wire logic I_CORE_CLK,               // core clock
  input wire logic I_RST_N,                  // async reset, low
  input wire logic I_INSN_VALID,             // instruction present
  input wire logic [XLEN-1:0] I_INSN,        // instruction word
  input wire logic [XLEN-1:0] I_SRC_DATA,    // source reg value
  input wire logic [XLEN-1:0] I_AMT_DATA,    // amount reg value
  input wire logic I_SO,                     // summary overflow
  output logic O_HIT,                        // instruction taken
  output logic O_GPR_WE,                     // target write
  output logic [REGW-1:0] O_GPR_ADDR,        // target index
  output logic [XLEN-1:0] O_GPR_DATA,        // target value
  output logic [XLEN-1:0] O_MQ,              // quotient register
  output logic O_CR0_WE,                     // field 0 write
  output logic [3:0] O_CR0,                  // field 0 value
  input wire logic [ADDR_W-1:0] I_AXI_AWADDR,   // write address
  input wire logic I_AXI_AWVALID,            // write addr valid
  output logic O_AXI_AWREADY,                // write addr ready
  input wire logic [XLEN-1:0] I_AXI_WDATA,   // write data
  input wire logic [3:0] I_AXI_WSTRB,        // byte enables
  input wire logic I_AXI_WVALID,             // write data valid
  output logic O_AXI_WREADY,                 // write data ready
  output logic [1:0] O_AXI_BRESP,            // write response
  output logic O_AXI_BVALID,                 // response valid
  input wire logic I_AXI_BREADY,             // response ready
  input wire logic [ADDR_W-1:0] I_AXI_ARADDR,   // read address
  input wire logic I_AXI_ARVALID,            // read addr valid
  output logic O_AXI_ARREADY,                // read addr ready
  output logic [XLEN-1:0] O_AXI_RDATA,       // read data
  output logic [1:0] O_AXI_RRESP,            // read response
  output logic O_AXI_RVALID,                 // read data valid
  input wire logic I_AXI_RREADY              // read data ready
);

  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  logic [XLEN-1:0] ctrl_r;
  logic [XLEN-1:0] mq_r;
  logic unit_en;
  logic op_match;
  op_kind_t op_kind;
  logic exec;
  logic rec;
  logic [REGW-1:0] tgt_idx;
  logic [SHW-1:0] cnt;
  logic zero_sel;
  logic [XLEN-1:0] rot;
  logic [XLEN-1:0] merged;
  logic [3:0] cr_nxt;
  logic mq_sw_wr;
  logic [ADDR_W-1:0] awaddr_r;
  logic [XLEN-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_full_r;
  logic w_full_r;
  logic wr_go;
  logic [15:0] op_cnt_r;

  function automatic logic [XLEN-1:0] wmask(input logic [3:0] s);
    logic [XLEN-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
      m[i*8 +: 8] = {8{s[i]}};
    return m;
  endfunction

  assign unit_en = ctrl_r[CTRL_EN_BIT];
  assign op_match = I_INSN[XLEN-1:POS_OP_LO] == PRIMARY_OP;

  always_comb
  begin
    op_kind = OP_NONE;
    if (I_INSN_VALID && unit_en && op_match)
    begin
      case (I_INSN[POS_XO_LO +: 10])
        XO_IMM_LONG: op_kind = OP_IMM;   // see RL1
        XO_REG_LONG: op_kind = OP_REG;   // see RL6
        default: op_kind = OP_NONE;
      endcase
    end
  end

  assign exec = op_kind != OP_NONE;
  assign rec = I_INSN[POS_RECORD];
  assign tgt_idx = I_INSN[POS_TGT_LO +: REGW];
  // immediate count from the instruction, else amount bits 27-31
  assign cnt = (op_kind == OP_IMM) ? I_INSN[POS_AMT_LO +: SHW]
    : I_AMT_DATA[POS_CNT_LO +: SHW];   // see RL7
  // mode bit only exists for the register form
  assign zero_sel = (op_kind == OP_REG) && I_AMT_DATA[POS_ZERO_SEL];

  // -------------------------------------------------------------
  // datapath
  // -------------------------------------------------------------
  sllq_rotmask u_rotmask (
    .i_src(I_SRC_DATA),
    .i_mq(mq_r),
    .i_cnt(cnt),
    .i_zero_sel(zero_sel),
    .o_rot(rot),
    .o_merged(merged)
  );

  sllq_cr0 u_cr0 (
    .i_result(merged),
    .i_so(I_SO),
    .o_cr(cr_nxt)
  );

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_HIT <= 1'b0;
      O_GPR_WE <= 1'b0;
      O_GPR_ADDR <= '0;
      O_GPR_DATA <= '0;
    end
    else
    begin
      O_HIT <= exec;
      O_GPR_WE <= exec;                      // see RL4, RL10
      if (exec)
      begin
        O_GPR_ADDR <= tgt_idx;
        O_GPR_DATA <= merged;                // see RL5, RL8, RL9
      end
    end
  end

  // condition field: no port towards the exception register exists
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_CR0_WE <= 1'b0;
      O_CR0 <= 4'h0;
    end
    else
    begin
      O_CR0_WE <= exec && rec;               // see RL12, RL11
      if (exec && rec)
        O_CR0 <= cr_nxt;                     // see RL13
    end
  end

  // hardware update wins over a software write in the same cycle
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      mq_r <= MQ_RST;
    else if (op_kind == OP_IMM)
      mq_r <= rot;                           // see RL4
    else if (mq_sw_wr)
      mq_r <= (mq_r & ~wmask(wstrb_r)) | (wdata_r & wmask(wstrb_r));
  end

  assign O_MQ = mq_r;

  // -------------------------------------------------------------
  // AXI4-Lite write channel
  // -------------------------------------------------------------
  assign wr_go = aw_full_r && w_full_r && !O_AXI_BVALID;
  assign mq_sw_wr = wr_go && (awaddr_r == ADDR_MQ);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      aw_full_r <= 1'b0;
      awaddr_r <= '0;
      O_AXI_AWREADY <= 1'b1;
    end
    else if (I_AXI_AWVALID && O_AXI_AWREADY)
    begin
      aw_full_r <= 1'b1;
      awaddr_r <= {I_AXI_AWADDR[ADDR_W-1:2], 2'b00};
      O_AXI_AWREADY <= 1'b0;
    end
    else if (O_AXI_BVALID && I_AXI_BREADY)
    begin
      aw_full_r <= 1'b0;
      O_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      w_full_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
      O_AXI_WREADY <= 1'b1;
    end
    else if (I_AXI_WVALID && O_AXI_WREADY)
    begin
      w_full_r <= 1'b1;
      wdata_r <= I_AXI_WDATA;
      wstrb_r <= I_AXI_WSTRB;
      O_AXI_WREADY <= 1'b0;
    end
    else if (O_AXI_BVALID && I_AXI_BREADY)
    begin
      w_full_r <= 1'b0;
      O_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_AXI_BVALID <= 1'b0;
      O_AXI_BRESP <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      O_AXI_BVALID <= 1'b1;
      // result and status are read-only
      O_AXI_BRESP <= (awaddr_r == ADDR_CTRL || awaddr_r == ADDR_MQ)
        ? RESP_OKAY : RESP_SLVERR;
    end
    else if (I_AXI_BREADY)
      O_AXI_BVALID <= 1'b0;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      ctrl_r <= CTRL_RST;
    else if (wr_go && awaddr_r == ADDR_CTRL)
      ctrl_r <= (ctrl_r & ~wmask(wstrb_r)) | (wdata_r & wmask(wstrb_r));
  end

  // wraps silently; software takes differences
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      op_cnt_r <= 16'h0000;
    else if (exec)
      op_cnt_r <= op_cnt_r + 16'h0001;
  end

  // -------------------------------------------------------------
  // AXI4-Lite read channel
  // -------------------------------------------------------------
  logic [XLEN-1:0] rd_mux;
  logic rd_hit;

  always_comb
  begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case ({I_AXI_ARADDR[ADDR_W-1:2], 2'b00})
      ADDR_CTRL: rd_mux = ctrl_r;
      ADDR_MQ: rd_mux = mq_r;
      ADDR_RESULT: rd_mux = O_GPR_DATA;
      ADDR_STATUS: rd_mux = {8'h00, O_CR0, 4'h0, op_cnt_r};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_AXI_ARREADY <= 1'b1;
      O_AXI_RVALID <= 1'b0;
      O_AXI_RDATA <= '0;
      O_AXI_RRESP <= RESP_OKAY;
    end
    else if (I_AXI_ARVALID && O_AXI_ARREADY)
    begin
      O_AXI_ARREADY <= 1'b0;
      O_AXI_RVALID <= 1'b1;
      O_AXI_RDATA <= rd_mux;
      O_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (O_AXI_RVALID && I_AXI_RREADY)
    begin
      O_AXI_RVALID <= 1'b0;
      O_AXI_ARREADY <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_imm_decode: assert property ( // see RL1
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (I_INSN_VALID && unit_en && I_INSN[31:26] == 6'd31
      && I_INSN[10:1] == 10'd248)
    |=> O_GPR_WE && O_GPR_ADDR == $past(I_INSN[20:16]))
    else $error("immediate form not taken");

  a_reg_decode: assert property ( // see RL6
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (I_INSN_VALID && unit_en && I_INSN[31:26] == 6'd31
      && I_INSN[10:1] == 10'd216)
    |=> O_GPR_WE && O_GPR_ADDR == $past(I_INSN[20:16]))
    else $error("register form not taken");

  a_imm_mq_rot: assert property ( // see RL2
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    op_kind == OP_IMM |=> O_MQ == (($past(I_SRC_DATA)
      << $past(I_INSN[15:11])) | ($past(I_SRC_DATA)
      >> (6'd32 - {1'b0, $past(I_INSN[15:11])}))))
    else $error("quotient reg not rotated source");

  a_imm_merge: assert property ( // see RL3
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    op_kind == OP_IMM ##1 1'b1 |-> O_GPR_DATA ==
      ((O_MQ & (32'hFFFF_FFFF << $past(I_INSN[15:11])))
      | ($past(mq_r) & ~(32'hFFFF_FFFF << $past(I_INSN[15:11])))))
    else $error("immediate merge wrong");

  a_rot_merge: assert property ( // see RL8
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    op_kind == OP_REG && !I_AMT_DATA[5] |=> O_GPR_DATA ==
      (((($past(I_SRC_DATA) << $past(I_AMT_DATA[4:0]))
      | ($past(I_SRC_DATA) >> (6'd32 - {1'b0, $past(I_AMT_DATA[4:0])})))
      & (32'hFFFF_FFFF << $past(I_AMT_DATA[4:0])))
      | ($past(mq_r) & ~(32'hFFFF_FFFF << $past(I_AMT_DATA[4:0])))))
    else $error("rotated merge wrong");

  a_zero_merge: assert property ( // see RL9
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    op_kind == OP_REG && I_AMT_DATA[5] |=> O_GPR_DATA ==
      ($past(mq_r) & (32'hFFFF_FFFF << $past(I_AMT_DATA[4:0]))))
    else $error("zero merge wrong");

  a_reg_mq_keep: assert property ( // see RL10
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    op_kind == OP_REG && !mq_sw_wr |=> $stable(O_MQ))
    else $error("register form altered quotient reg");

  a_cr0_record: assert property ( // see RL13
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    exec && rec |=> O_CR0_WE && O_CR0 == {$signed(O_GPR_DATA) < 0,
      $signed(O_GPR_DATA) > 0, O_GPR_DATA == 32'h0000_0000, $past(I_SO)})
    else $error("condition field wrong");

  a_cr0_hold: assert property ( // see RL12
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    !(exec && rec) |=> !O_CR0_WE && $stable(O_CR0))
    else $error("condition field changed without record");

endmodule
`default_nettype wire

// >>> sllq_feeder.sv
// decoder and register file stand-in feeding the long-shift unit
// assumes: testbench calls issue and idle right after a rising edge
`timescale 1ns/10ps
`default_nettype none
module sllq_feeder
  import sllq_pkg::*;
(
  input wire logic i_clk,                  // core clock
  input wire logic i_gpr_we,               // write-back strobe
  input wire logic [REGW-1:0] i_gpr_addr,  // write-back index
  input wire logic [XLEN-1:0] i_gpr_data,  // write-back value
  output logic o_valid,                    // instruction present
  output logic [XLEN-1:0] o_insn,          // instruction word
  output logic [XLEN-1:0] o_src,           // source operand
  output logic [XLEN-1:0] o_amt,           // amount operand
  output logic o_so                        // summary overflow
);
  logic [XLEN-1:0] gpr [32];

  initial
  begin
    o_valid = 1'b0;
    o_insn = '0;
    o_src = '0;
    o_amt = '0;
    o_so = 1'b0;
  end

  // write-back lands in the file the decoder reads next
  always @(posedge i_clk)
  begin
    if (i_gpr_we === 1'b1)
      gpr[i_gpr_addr] <= i_gpr_data;
  end

  task automatic issue(input logic [XLEN-1:0] w, input logic so);
    o_insn <= w;
    o_src <= gpr[w[25:21]];
    o_amt <= gpr[w[15:11]];
    o_so <= so;
    o_valid <= 1'b1;
    @(posedge i_clk);
  endtask

  // stale operands flip so a late sample cannot pass by luck
  task automatic idle;
    o_valid <= 1'b0;
    o_insn <= ~o_insn;
    o_src <= ~o_src;
    o_amt <= ~o_amt;
    @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the long-shift unit with a reference model
// assumes: sllq_feeder plays decoder and register file
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sllq_pkg::*;
  typedef struct {logic [4:0] a; logic [31:0] d; logic [31:0] m;
                  logic r; logic [3:0] c;} exp_t;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, insn, src, amt, o_gpr_data, o_mq, o_rdata;
  logic [3:0] wstrb, o_cr0;
  logic [1:0] o_bresp, o_rresp;
  logic [4:0] o_gpr_addr;
  logic ivalid, so, o_hit, o_gpr_we, o_cr0_we, o_awready, o_wready;
  logic o_bvalid, o_arready, o_rvalid, m_en;
  logic [31:0] m_mq, m_last, t;
  logic [3:0] m_cr;
  int m_cnt, error_cnt, samples_checked, cyc;
  exp_t q[$];
  exp_t e;

  sllq_unit dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_INSN_VALID(ivalid),
    .I_INSN(insn), .I_SRC_DATA(src), .I_AMT_DATA(amt), .I_SO(so),
    .O_HIT(o_hit), .O_GPR_WE(o_gpr_we), .O_GPR_ADDR(o_gpr_addr),
    .O_GPR_DATA(o_gpr_data), .O_MQ(o_mq), .O_CR0_WE(o_cr0_we),
    .O_CR0(o_cr0), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(o_awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb),
    .I_AXI_WVALID(wvalid), .O_AXI_WREADY(o_wready), .O_AXI_BRESP(o_bresp),
    .O_AXI_BVALID(o_bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid),
    .O_AXI_ARREADY(o_arready), .O_AXI_RDATA(o_rdata),
    .O_AXI_RRESP(o_rresp), .O_AXI_RVALID(o_rvalid), .I_AXI_RREADY(rready));

  sllq_feeder ptr (.i_clk(clk), .i_gpr_we(o_gpr_we),
    .i_gpr_addr(o_gpr_addr), .i_gpr_data(o_gpr_data), .o_valid(ivalid),
    .o_insn(insn), .o_src(src), .o_amt(amt), .o_so(so));

  always #2 clk = ~clk;

  task automatic close_out;
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ev,
                     input logic [31:0] gv);
    samples_checked++;
    if (gv !== ev)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, ev, gv);
    end
  endtask

  // ---------------------------------------------------------------
  // bus master
  // ---------------------------------------------------------------
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk);
      if (!aw && o_awready === 1'b1)
      begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && o_wready === 1'b1)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (o_bvalid !== 1'b1) @(posedge clk);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, o_bresp});
    @(posedge clk);
  endtask

  task automatic axr(input logic [11:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (o_arready !== 1'b1);
    arvalid <= 1'b0;
    while (o_rvalid !== 1'b1) @(posedge clk);
    rready <= 1'b0;
    chk("rdata", ed, o_rdata);
    chk("rresp", {30'h0, er}, {30'h0, o_rresp});
    @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // reference model and result monitor
  // ---------------------------------------------------------------
  task automatic run(input logic imm, input logic [4:0] rs,
    input logic [4:0] ra, input logic [4:0] x, input logic rec,
    input logic s, input logic [31:0] vs, input logic [31:0] va);
    logic [31:0] rot, m, r;
    logic [4:0] n;
    logic [3:0] c;
    ptr.gpr[rs] = vs;
    if (!imm)
      ptr.gpr[x] = va;
    n = imm ? x : va[4:0];
    rot = (vs << n) | (vs >> (6'd32 - n));
    m = ONES << n;
    if (!imm && va[5])
      r = m_mq & m;
    else
      r = (rot & m) | (m_mq & ~m);
    c = {$signed(r) < 0, $signed(r) > 0, r == 0, s};
    if (m_en)
    begin
      if (imm)
        m_mq = rot;
      m_last = r;
      m_cnt++;
      if (rec)
        m_cr = c;
      q.push_back('{ra, r, m_mq, rec, c});
    end
    ptr.issue({PRIMARY_OP, rs, ra, x, imm ? XO_IMM_LONG : XO_REG_LONG,
               rec}, s);
  endtask

  always @(posedge clk)
  begin
    if (o_hit === 1'b1)
    begin
      if (q.size() == 0)
        chk("hit", 32'h0, 32'h1);
      else
      begin
        e = q.pop_front();
        chk("we", 32'h1, {31'h0, o_gpr_we});
        chk("addr", {27'h0, e.a}, {27'h0, o_gpr_addr});
        chk("data", e.d, o_gpr_data);
        chk("mq", e.m, o_mq);
        chk("crwe", {31'h0, e.r}, {31'h0, o_cr0_we});
        if (e.r)
          chk("cr0", {28'h0, e.c}, {28'h0, o_cr0});
      end
    end
  end

  // hang guard well above the roughly two hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {m_mq, m_last, m_cr, m_cnt, m_en} = {MQ_RST, 32'h0, 4'h0, 32'h0, 1'b1};
    void'($urandom(71537));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    axr(ADDR_CTRL, CTRL_RST, RESP_OKAY);
    axr(ADDR_MQ, MQ_RST, RESP_OKAY);
    axw(ADDR_MQ, ONES, 4'hF, RESP_OKAY);
    m_mq = ONES;
    run(1, 5'd4, 5'd6, 5'd4, 1, 0, 32'hB004_3000, 0);
    run(0, 5'd4, 5'd6, 5'd5, 1, 1, 32'hB004_3000, 4);
    run(0, 5'd4, 5'd7, 5'd5, 0, 0, 32'h9000_3000, 32'h24);
    ptr.idle();
    axw(ADDR_CTRL, 32'h0, 4'hF, RESP_OKAY);
    m_en = 1'b0;
    run(1, 5'd1, 5'd9, 5'd7, 1, 0, 32'h1234_5678, 0);
    ptr.idle();
    axw(ADDR_CTRL, 32'h1, 4'hF, RESP_OKAY);
    m_en = 1'b1;
    ptr.issue({PRIMARY_OP, 15'h0, 10'h0D9, 1'b1}, 0);
    ptr.issue({6'h1E, 15'h0, XO_IMM_LONG, 1'b1}, 0);
    ptr.idle();
    axw(ADDR_RESULT, 32'h0, 4'hF, RESP_SLVERR);
    axr(12'h010, 32'h0, RESP_SLVERR);
    axw(ADDR_MQ, 32'h1234_5678, 4'h3, RESP_OKAY);
    m_mq = {m_mq[31:16], 16'h5678};
    axr(ADDR_MQ, m_mq, RESP_OKAY);
    repeat (80)
    begin
      t = $urandom;
      run(t[0], {2'b00, t[8:6]}, {1'b1, t[12:9]},
          t[0] ? t[5:1] : {2'b01, t[3:1]}, t[13], t[14],
          $urandom, $urandom);
      if (t[15])
        ptr.idle();
    end
    ptr.idle();
    repeat (3) @(posedge clk);
    chk("pending", 32'h0, 32'(q.size()));
    axr(ADDR_RESULT, m_last, RESP_OKAY);
    axr(ADDR_STATUS, {8'h0, m_cr, 4'h0, m_cnt[15:0]}, RESP_OKAY);
    close_out();
  end
endmodule
`default_nettype wire
